// ===== core/tmc_pkg.sv
// Package of constants and carrier types for the tape motion control block
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Run latch plus set-enable sets motion command
// - Busy rise-then-fall starts six-microsecond timing chain
// - Pause off: step six gives set-enable
// - Pause on: step six starts adjustable delay
// - Not ready clears and blocks motion command
// - Master clear clears motion command
// - Operation finished clears motion command
// - Reverse at beginning of tape clears command
// - Forward at tape limit clears unless gapping
// - Gap done during gap clears command
// - Tach count outside BOT ends gap
// - Stop pulse or command start zeroes counters
// - BOT latch blocks writing until count 400 octal
// - Internal test makes ready, masks transport status
// - Simulated busy follows command, 100 us tail
// - Start/stop test passes ready, busy, BOT, limit
// - Simulated velocity 1 ms, permit 1 us later
// - Command low drops velocity and permit together
// - Outside test, pass transport velocity and permit
// - Monitor latch holds 25 ms after signal
// - Fault latch set by lines, button clears
// - Permit without velocity sets permit error
// - Permit error cleared by its button
// - Stop pulse clears record gap latch
//////////////////////////////////////////////////////////////////////////////
package tmc_pkg;

  // Clock and time
  localparam int CLK_NS         = 10;
  localparam int US_NS          = 1000;
  localparam int MS_NS          = 1000000;
  localparam int CHAIN_STEPS    = 6;
  localparam int IDLE_US        = 50;
  localparam int BUSY_HOLD_US   = 100;
  localparam int PERMIT_DLY_US  = 1;
  localparam int VEL_DLY_MS     = 1;
  localparam int MON_HOLD_MS    = 25;
  localparam int PAUSE_MIN_MS   = 2;
  localparam int PAUSE_MAX_MS   = 100;
  localparam int CHAIN_CYC      = CHAIN_STEPS * US_NS / CLK_NS;
  localparam int PERMIT_DLY_CYC = PERMIT_DLY_US * US_NS / CLK_NS;
  localparam int MS_CYC         = MS_NS / CLK_NS;
  localparam int IDLE_CYC       = IDLE_US * US_NS / CLK_NS;
  localparam int BUSY_HOLD_CYC  = BUSY_HOLD_US * US_NS / CLK_NS;
  localparam int VEL_DLY_CYC    = VEL_DLY_MS * MS_CYC;
  localparam int MON_HOLD_CYC   = MON_HOLD_MS * MS_CYC;

  // Counter widths
  localparam int CW             = 24;
  localparam int TW             = 10;

  // Tachometer thresholds: 1000 and 400 octal
  localparam logic [TW-1:0] TACH_GAP_DONE = 10'h200;
  localparam logic [TW-1:0] TACH_BOT_END  = 10'h100;
  localparam logic [TW-1:0] TACH_MAX      = 10'h3FF;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CMD    = 4'h4;
  localparam logic [3:0] ADDR_PAUSE  = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // Command register bits (write one to pulse)
  localparam int CMD_START    = 0;
  localparam int CMD_PERR_CLR = 1;

  // Status register field positions
  localparam int ST_TACH_LSB  = 16;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [6:0] PAUSE_RST = 7'h64;

  typedef struct packed {
    logic       ready;
    logic       busy;
    logic       bot;
    logic       tape_limit_marker;
    logic       load_point;
    logic       tach;
    logic       velocity;
    logic       write_permit;
    logic [4:0] fault;
    logic       data_strobe;
  } tmc_tp_in_t;

  // Operator controls, bit order equals CTRL register bits 7..0
  typedef struct packed {
    logic master_clear;
    logic rec_mode;
    logic fault_btn;
    logic ss_test;
    logic int_test;
    logic pause_en;
    logic run_mode;
    logic spare;
  } tmc_ctrl_t;

  typedef struct packed {
    tmc_tp_in_t      sync1;
    tmc_tp_in_t      sync2;
    logic            busy_prev;
    logic            tach_prev;
    logic            strobe_prev;
    logic            go_prev;
    logic            busy_seen;
    logic            chain_on;
    logic [CW-1:0]   chain_cnt;
    logic            pause;
    logic [CW-1:0]   pause_cnt;
    logic            repeat_run;
    logic            go;
    logic            data_seen;
    logic [CW-1:0]   idle_cnt;
    logic [TW-1:0]   tach_cnt;
    logic            gap;
    logic            gap_done;
    logic            bot_latch;
    logic            sim_busy;
    logic [CW-1:0]   busy_cnt;
    logic            sim_vel;
    logic            sim_permit;
    logic [CW-1:0]   vel_cnt;
    logic            monitor;
    logic [CW-1:0]   mon_cnt;
    logic            fault;
    logic            perr;
    logic            ready_o;
    logic            busy_o;
    logic            vel_o;
    logic            permit_o;
    logic            finished;
  } tmc_op_t;

  typedef struct packed {
    tmc_ctrl_t   ctrl;
    logic [6:0]  pause_ms;
    logic        ack;
    logic [31:0] rdata;
    tmc_op_t     op;
  } tmc_state_t;

endpackage : tmc_pkg

// ===== core/tmc_motion_ctrl.sv
// Motion command sequencing, test simulation and error latches of the exerciser
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module tmc_motion_ctrl #(
  parameter int MS_CYC        = tmc_pkg::MS_CYC,
  parameter int IDLE_CYC      = tmc_pkg::IDLE_CYC,
  parameter int BUSY_HOLD_CYC = tmc_pkg::BUSY_HOLD_CYC,
  parameter int VEL_DLY_CYC   = tmc_pkg::VEL_DLY_CYC,
  parameter int MON_HOLD_CYC  = tmc_pkg::MON_HOLD_CYC
) (
  input  wire logic               SYS_CLK_I,
  input  wire logic               SRST_I,
  input  wire logic [3:0]         AVS_ADDRESS_I,
  input  wire logic               AVS_READ_I,
  input  wire logic               AVS_WRITE_I,
  input  wire logic [31:0]        AVS_WRITEDATA_I,
  input  wire logic [3:0]         AVS_BYTEENABLE_I,
  output logic [31:0]             AVS_READDATA_O,
  output logic                    AVS_WAITREQUEST_O,
  input  wire tmc_pkg::tmc_tp_in_t TP_STATUS_I,
  input  wire logic               FWD_INSTR_I,
  input  wire logic               REV_INSTR_I,
  input  wire logic               GAP_START_I,
  input  wire logic               MON_SIGNAL_I,
  output logic                    MOTION_CMD_O,
  output logic                    READY_O,
  output logic                    BUSY_O,
  output logic                    VELOCITY_O,
  output logic                    WRITE_PERMIT_O,
  output logic                    WRITE_ENABLE_O,
  output logic                    GAP_ACTIVE_O,
  output logic                    OPERATION_FINISHED_O,
  output logic                    MONITOR_O,
  output logic                    FAULT_O,
  output logic                    PERMIT_ERROR_O
);

  tmc_pkg::tmc_state_t q;
  tmc_pkg::tmc_state_t d;

  localparam tmc_pkg::tmc_state_t STATE_RST = '{
    ctrl:     tmc_pkg::CTRL_RST,
    pause_ms: tmc_pkg::PAUSE_RST,
    ack:      1'b0,
    rdata:    32'h0000_0000,
    op:       '0
  };

  localparam logic [tmc_pkg::CW-1:0] CHAIN_END =
    tmc_pkg::CW'(tmc_pkg::CHAIN_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] PERMIT_END =
    tmc_pkg::CW'(tmc_pkg::PERMIT_DLY_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] IDLE_END  = tmc_pkg::CW'(IDLE_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] BHOLD_END =
    tmc_pkg::CW'(BUSY_HOLD_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] VEL_END   = tmc_pkg::CW'(VEL_DLY_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] MON_END   = tmc_pkg::CW'(MON_HOLD_CYC - 1);
  localparam logic [tmc_pkg::CW-1:0] MS_CW     = tmc_pkg::CW'(MS_CYC);
  localparam logic [6:0] PMIN = 7'(tmc_pkg::PAUSE_MIN_MS);
  localparam logic [6:0] PMAX = 7'(tmc_pkg::PAUSE_MAX_MS);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    tmc_pkg::tmc_tp_in_t tp;
    logic                bus_req;
    logic                wr_go;
    logic                start;
    logic                perr_clr;
    logic                full_sim;
    logic                rx_sim;
    logic                rdy;
    logic                busy;
    logic                bot;
    logic                limit;
    logic                load_pt;
    logic [4:0]          fault_ln;
    logic                busy_rise;
    logic                busy_fall;
    logic                t6;
    logic                pause_done;
    logic                set_en;
    logic                idle_done;
    logic                finished;
    logic                go_clr;
    logic                go_set;
    logic                go_rise;
    logic                tach_edge;
    logic                vel_now;
    logic                permit_now;
    logic [6:0]          pms;
    logic [tmc_pkg::CW-1:0] pause_end;

    d          = q;
    tp         = q.op.sync2;
    bus_req    = AVS_READ_I | AVS_WRITE_I;
    wr_go      = AVS_WRITE_I & q.ack & AVS_BYTEENABLE_I[0];
    start      = wr_go && AVS_ADDRESS_I == tmc_pkg::ADDR_CMD
                 && AVS_WRITEDATA_I[tmc_pkg::CMD_START];
    perr_clr   = wr_go && AVS_ADDRESS_I == tmc_pkg::ADDR_CMD
                 && AVS_WRITEDATA_I[tmc_pkg::CMD_PERR_CLR];

    // Two-stage synchronisers on transport lines
    d.op.sync1 = TP_STATUS_I;
    d.op.sync2 = q.op.sync1;

    // Receiver gating for the test modes
    full_sim = q.ctrl.int_test;
    rx_sim   = q.ctrl.int_test | q.ctrl.ss_test;
    rdy      = full_sim ? 1'b1 : tp.ready;
    busy     = full_sim ? q.op.sim_busy : tp.busy;
    bot      = full_sim ? 1'b0 : tp.bot;
    limit    = full_sim ? 1'b0 : tp.tape_limit_marker;
    load_pt  = full_sim ? 1'b0 : tp.load_point;
    fault_ln = rx_sim ? 5'h00 : tp.fault;

    d.op.busy_prev   = busy;
    d.op.tach_prev   = tp.tach;
    d.op.strobe_prev = tp.data_strobe;
    d.op.go_prev     = q.op.go;
    busy_rise        = busy & ~q.op.busy_prev;
    busy_fall        = ~busy & q.op.busy_prev;
    go_rise          = q.op.go & ~q.op.go_prev;
    tach_edge        = tp.tach & ~q.op.tach_prev;

    // Timing chain, armed by a busy rise, launched by the fall
    t6 = 1'b0;
    if (busy_rise) begin
      d.op.busy_seen = 1'b1;
    end
    if (busy_fall && q.op.busy_seen) begin
      d.op.busy_seen = 1'b0;
      d.op.chain_on  = 1'b1;
      d.op.chain_cnt = '0;
    end else if (q.op.chain_on) begin
      if (q.op.gap) begin
        d.op.chain_on = 1'b0;
      end else if (q.op.chain_cnt == CHAIN_END) begin
        d.op.chain_on = 1'b0;
        t6            = 1'b1;
      end else begin
        d.op.chain_cnt = q.op.chain_cnt + 1'b1;
      end
    end

    // Pause delay, clamped to its legal range
    pms = q.pause_ms;
    if (pms < PMIN) begin
      pms = PMIN;
    end else if (pms > PMAX) begin
      pms = PMAX;
    end
    pause_end  = tmc_pkg::CW'(pms * MS_CW - 1'b1);
    pause_done = 1'b0;
    if (t6 && q.ctrl.pause_en) begin
      d.op.pause     = 1'b1;
      d.op.pause_cnt = '0;
    end else if (q.op.pause) begin
      if (q.op.pause_cnt >= pause_end) begin
        d.op.pause = 1'b0;
        pause_done = 1'b1;
      end else begin
        d.op.pause_cnt = q.op.pause_cnt + 1'b1;
      end
    end
    set_en = (t6 & ~q.ctrl.pause_en) | pause_done;

    // Continuous-run latch; step mode drops it once start has gone
    if (start) begin
      d.op.repeat_run = 1'b1;
    end else if (!q.ctrl.run_mode) begin
      d.op.repeat_run = 1'b0;
    end

    // Internal operation_finished: data then 50 us of silence
    idle_done = 1'b0;
    if (tp.data_strobe & ~q.op.strobe_prev) begin
      d.op.data_seen = 1'b1;
      d.op.idle_cnt  = '0;
    end else if (q.op.data_seen) begin
      if (q.op.idle_cnt == IDLE_END) begin
        d.op.data_seen = 1'b0;
        idle_done      = 1'b1;
      end else begin
        d.op.idle_cnt = q.op.idle_cnt + 1'b1;
      end
    end
    finished = q.ctrl.rec_mode ? idle_done : (load_pt | limit);
    d.op.finished = finished;

    // Motion command latch; every clear beats every set
    go_clr = ~rdy
           | finished
           | (REV_INSTR_I & bot)
           | (FWD_INSTR_I & limit & ~q.op.gap)
           | (q.op.gap & q.op.gap_done);
    go_set = (q.op.repeat_run & set_en) | start;
    if (go_clr) begin
      d.op.go = 1'b0;
    end else if (go_set) begin
      d.op.go = 1'b1;
    end

    // Tachometer counter, zeroed on stop pulse or command start
    if (busy_fall || go_rise) begin
      d.op.tach_cnt = '0;
    end else if (tach_edge && !bot && q.op.tach_cnt != tmc_pkg::TACH_MAX) begin
      d.op.tach_cnt = q.op.tach_cnt + 1'b1;
    end
    if (q.op.gap && q.op.tach_cnt == tmc_pkg::TACH_GAP_DONE) begin
      d.op.gap_done = 1'b1;
    end else if (busy_fall) begin
      d.op.gap_done = 1'b0;
    end

    // Record gap latch: a new start wins over the stop pulse
    if (GAP_START_I) begin
      d.op.gap = 1'b1;
    end else if (busy_fall) begin
      d.op.gap = 1'b0;
    end

    // Beginning-of-tape write guard
    if (bot) begin
      d.op.bot_latch = 1'b1;
    end else if (q.op.tach_cnt == tmc_pkg::TACH_BOT_END) begin
      d.op.bot_latch = 1'b0;
    end

    // Simulated busy with its 100 us tail
    if (q.op.go) begin
      d.op.sim_busy = 1'b1;
      d.op.busy_cnt = '0;
    end else if (q.op.sim_busy) begin
      if (q.op.busy_cnt == BHOLD_END) begin
        d.op.sim_busy = 1'b0;
      end else begin
        d.op.busy_cnt = q.op.busy_cnt + 1'b1;
      end
    end

    // Simulated velocity, then write permit; one counter serves both
    if (!q.op.go) begin
      d.op.sim_vel    = 1'b0;
      d.op.sim_permit = 1'b0;
      d.op.vel_cnt    = '0;
    end else if (!q.op.sim_vel) begin
      if (q.op.vel_cnt == VEL_END) begin
        d.op.sim_vel = 1'b1;
        d.op.vel_cnt = '0;
      end else begin
        d.op.vel_cnt = q.op.vel_cnt + 1'b1;
      end
    end else if (!q.op.sim_permit) begin
      if (q.op.vel_cnt == PERMIT_END) begin
        d.op.sim_permit = 1'b1;
      end else begin
        d.op.vel_cnt = q.op.vel_cnt + 1'b1;
      end
    end
    // Gated by go so velocity and permit drop together with the command
    vel_now    = rx_sim ? q.op.sim_vel & q.op.go : tp.velocity;
    permit_now = rx_sim ? q.op.sim_permit & q.op.go : tp.write_permit;

    // Monitor lamp stretcher
    if (MON_SIGNAL_I) begin
      d.op.monitor = 1'b1;
      d.op.mon_cnt = '0;
    end else if (q.op.monitor) begin
      if (q.op.mon_cnt == MON_END) begin
        d.op.monitor = 1'b0;
      end else begin
        d.op.mon_cnt = q.op.mon_cnt + 1'b1;
      end
    end

    // Fault lamp: button held wins, lines re-set it on release
    if (q.ctrl.fault_btn) begin
      d.op.fault = 1'b0;
    end else if (|fault_ln) begin
      d.op.fault = 1'b1;
    end

    // Permit error; a fresh error beats the clear button
    if (permit_now && !vel_now) begin
      d.op.perr = 1'b1;
    end else if (perr_clr) begin
      d.op.perr = 1'b0;
    end

    d.op.ready_o  = rdy;
    d.op.busy_o   = busy;
    d.op.vel_o    = vel_now;
    d.op.permit_o = permit_now;

    // Avalon slave: one wait cycle, data registered meanwhile
    d.ack   = bus_req & ~q.ack;
    d.rdata = 32'h0000_0000;
    if (AVS_READ_I && !q.ack) begin
      unique case (AVS_ADDRESS_I)
        tmc_pkg::ADDR_CTRL:  d.rdata[7:0] = q.ctrl;
        tmc_pkg::ADDR_PAUSE: d.rdata[6:0] = q.pause_ms;
        tmc_pkg::ADDR_STATUS: begin
          d.rdata[15:0] = {q.op.ready_o, q.op.busy_o, q.op.go,
                           q.op.repeat_run, q.op.pause, q.op.gap,
                           q.op.gap_done, q.op.bot_latch, q.op.sim_busy,
                           q.op.vel_o, q.op.permit_o, q.op.monitor,
                           q.op.fault, q.op.perr, q.op.chain_on,
                           q.op.data_seen};
          d.rdata[tmc_pkg::ST_TACH_LSB +: tmc_pkg::TW] = q.op.tach_cnt;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go && AVS_ADDRESS_I == tmc_pkg::ADDR_CTRL) begin
      d.ctrl = AVS_WRITEDATA_I[7:0];
    end
    if (wr_go && AVS_ADDRESS_I == tmc_pkg::ADDR_PAUSE) begin
      d.pause_ms = AVS_WRITEDATA_I[6:0];
    end

    // Master clear resets the whole sequencer, not the registers
    if (q.ctrl.master_clear) begin
      d.op = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign AVS_WAITREQUEST_O    = (AVS_READ_I | AVS_WRITE_I) & ~q.ack;
  assign AVS_READDATA_O       = q.rdata;
  assign MOTION_CMD_O         = q.op.go;
  assign READY_O              = q.op.ready_o;
  assign BUSY_O               = q.op.busy_o;
  assign VELOCITY_O           = q.op.vel_o;
  assign WRITE_PERMIT_O       = q.op.permit_o;
  assign WRITE_ENABLE_O       = ~q.op.bot_latch;
  assign GAP_ACTIVE_O         = q.op.gap;
  assign OPERATION_FINISHED_O = q.op.finished;
  assign MONITOR_O            = q.op.monitor;
  assign FAULT_O              = q.op.fault;
  assign PERMIT_ERROR_O       = q.op.perr;

endmodule : tmc_motion_ctrl

// ===== testbench/tmc_motion_ctrl_props.sv
// Port-level assertions for the motion control block
`timescale 1ns/1ps
module tmc_motion_ctrl_props (
  input wire logic        SYS_CLK_I,
  input wire logic        SRST_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        MON_SIGNAL_I,
  input wire logic        MOTION_CMD_O,
  input wire logic        READY_O,
  input wire logic        BUSY_O,
  input wire logic        VELOCITY_O,
  input wire logic        WRITE_PERMIT_O,
  input wire logic        MONITOR_O,
  input wire logic        FAULT_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q;
  logic       it;
  logic       mc;
  // Shadow rebuilt from bus traffic; assumes byte lane 0 always enabled
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ctrl_q <= 8'h00;
    end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O
                 && AVS_ADDRESS_I == 4'h0) begin
      ctrl_q <= AVS_WRITEDATA_I[7:0];
    end
  end
  assign it = ctrl_q[3] & ~ctrl_q[7];
  assign mc = ctrl_q[7];
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_one_wait;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endsequence
  sequence s_busy_tail;
    BUSY_O [*8];
  endsequence
  chk_bus_wait: assert property (
    $rose(AVS_READ_I | AVS_WRITE_I) |-> s_one_wait)
    else $error("Bus answer not after one wait");
  chk_ready_int: assert property (
    it && $past(it) |-> READY_O) else $error("Internal ready missing");
  chk_busy_follow: assert property (
    it && $rose(MOTION_CMD_O) |-> ##[1:3] BUSY_O ##1 BUSY_O)
    else $error("Simulated busy late");
  chk_busy_tail: assert property (
    it && $fell(MOTION_CMD_O) |-> s_busy_tail)
    else $error("Simulated busy dropped early");
  chk_vel_drop: assert property (
    it && $fell(MOTION_CMD_O) |-> ##[0:1] !(VELOCITY_O | WRITE_PERMIT_O))
    else $error("Velocity or permit kept");
  chk_permit_lag: assert property (
    it && $rose(WRITE_PERMIT_O) |-> VELOCITY_O && $past(VELOCITY_O, 99))
    else $error("Permit too soon after velocity");
  chk_mon_hold: assert property (
    !mc && $fell(MON_SIGNAL_I) |=> MONITOR_O [*8])
    else $error("Monitor not held");
  chk_fault_btn: assert property (
    ctrl_q[5] && $past(ctrl_q[5]) |-> !FAULT_O)
    else $error("Fault kept under button");
  chk_cmd_ready: assert property (
    !READY_O && $past(!READY_O) |-> !MOTION_CMD_O)
    else $error("Motion while not ready");
endmodule : tmc_motion_ctrl_props
bind tmc_motion_ctrl tmc_motion_ctrl_props tmc_motion_ctrl_props_inst (.*);

// ===== testbench/tmc_tape_model.sv
// Behavioural tape transport facing the motion control block
`timescale 1ns/1ps
module tmc_tape_model #(
  parameter int LAG = 8
) (
  input  wire logic           clk_i,
  input  wire logic           motion_i,
  input  wire logic           ready_i,
  input  wire logic           bot_i,
  input  wire logic           lim_i,
  input  wire logic           permit_i,
  input  wire logic [4:0]     fault_i,
  output tmc_pkg::tmc_tp_in_t tp_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] lag_q = 8'h00;
  logic       busy_q = 1'b0;
  logic       tach_q = 1'b0;
  // Capstan lags the command both ways, so busy falls after motion drops
  always_ff @(posedge clk_i) begin
    lag_q  <= (motion_i != busy_q) ? lag_q + 8'h01 : 8'h00;
    tach_q <= busy_q & ~tach_q;
    if (lag_q == 8'(LAG)) begin
      busy_q <= motion_i;
    end
  end
  always_comb begin
    tp_o              = '0;
    tp_o.ready        = ready_i;
    tp_o.busy         = busy_q;
    tp_o.bot          = bot_i;
    tp_o.tape_limit_marker = lim_i;
    tp_o.tach         = tach_q;
    tp_o.velocity     = busy_q;
    tp_o.write_permit = permit_i;
    tp_o.fault        = fault_i;
  end
endmodule : tmc_tape_model

// ===== testbench/tape_exerciser_motion_control_tb.sv
// Self-checking bench for the tape motion control block
`timescale 1ns/1ps
module tape_exerciser_motion_control_tb;
  localparam int VEL = 40;
  logic                sys_clk = 1'b0;
  logic                srst = 1'b1;
  logic [3:0]          a_q = 4'h0;
  logic                rd_q = 1'b0;
  logic                wr_q = 1'b0;
  logic [31:0]         wd_q = 32'h0000_0000;
  logic [31:0]         rdat;
  logic                wait_o;
  tmc_pkg::tmc_tp_in_t tp;
  logic                rev = 1'b0;
  logic                gap_go = 1'b0;
  logic                mon = 1'b0;
  logic                rdy_en = 1'b0;
  logic                bot = 1'b0;
  logic                pmt = 1'b0;
  logic [4:0]          flts = 5'h00;
  logic [3:0]          be = 4'hF;
  logic                fwd = 1'b0;
  logic                lim = 1'b0;
  logic                mot, rdy, bsy, vel, wpm, wen, gap, moni, flt, perr, fin;
  logic [31:0]         rd;
  int                  n;
  int                  err_total = 0;
  int                  tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  tmc_motion_ctrl #(.MS_CYC(10), .IDLE_CYC(20), .BUSY_HOLD_CYC(30),
    .VEL_DLY_CYC(VEL), .MON_HOLD_CYC(50)) tmc_motion_ctrl_inst (
    .SYS_CLK_I(sys_clk), .SRST_I(srst), .AVS_ADDRESS_I(a_q),
    .AVS_READ_I(rd_q), .AVS_WRITE_I(wr_q), .AVS_WRITEDATA_I(wd_q),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_o), .TP_STATUS_I(tp), .FWD_INSTR_I(fwd),
    .REV_INSTR_I(rev), .GAP_START_I(gap_go), .MON_SIGNAL_I(mon),
    .MOTION_CMD_O(mot), .READY_O(rdy), .BUSY_O(bsy), .VELOCITY_O(vel),
    .WRITE_PERMIT_O(wpm), .WRITE_ENABLE_O(wen), .GAP_ACTIVE_O(gap),
    .OPERATION_FINISHED_O(fin), .MONITOR_O(moni), .FAULT_O(flt),
    .PERMIT_ERROR_O(perr));
  tmc_tape_model tmc_tape_model_inst (.clk_i(sys_clk), .motion_i(mot),
    .ready_i(rdy_en), .bot_i(bot), .lim_i(lim), .permit_i(pmt),
    .fault_i(flts), .tp_o(tp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    rd_q <= !w;
    wr_q <= w;
    a_q  <= a;
    wd_q <= d;
    // Request stands until waitrequest is sampled low at a rising edge
    do @(posedge sys_clk); while (wait_o !== 1'b0);
    q = rdat;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wreg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic till(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : till
  task automatic hold(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : hold
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    be <= 4'hE;
    wreg(4'h8, 32'h0000_0011);
    be <= 4'hF;
    bus(1'b0, 4'h8, 32'h0, rd);
    chk(rd, 32'h0000_0064);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk(rd, 32'h0000_0000);
  endtask : t_regs
  task automatic t_intest;
    wreg(4'h0, 32'h08);
    hold(3);
    chk(rdy, 1'b1);
    wreg(4'h4, 32'h01);
    till(bsy, 1'b1, n);
    chk(mot, 1'b1);
    @(posedge sys_clk);
    gap_go <= 1'b1;
    @(posedge sys_clk);
    gap_go <= 1'b0;
    till(vel, 1'b1, n);
    chk(n >= VEL - 6 && n <= VEL, 1'b1);
    till(wpm, 1'b1, n);
    chk(n >= 99 && n <= 101, 1'b1);
    chk(gap, 1'b1);
    till(mot, 1'b0, n);
    chk(n >= 860 && n <= 940, 1'b1);
    hold(1);
    chk({vel, wpm, bsy}, 3'b001);
    till(bsy, 1'b0, n);
    chk(n >= 28 && n <= 32, 1'b1);
    hold(3);
    chk(gap, 1'b0);
    wreg(4'h4, 32'h01);
    wreg(4'h0, 32'h88);
    hold(2);
    chk({mot, bsy}, 2'b00);
    wreg(4'h0, 32'h00);
  endtask : t_intest
  task automatic t_cycle(input logic [31:0] ctl, input int extra);
    @(posedge sys_clk);
    rdy_en <= 1'b1;
    wreg(4'h0, ctl);
    hold(6);
    wreg(4'h4, 32'h01);
    till(vel, 1'b1, n);
    chk({mot, n < 40}, 2'b11);
    @(posedge sys_clk);
    rev <= 1'b1;
    bot <= 1'b1;
    till(mot, 1'b0, n);
    chk(n < 8, 1'b1);
    @(posedge sys_clk);
    rev <= 1'b0;
    till(mot, 1'b1, n);
    chk(n >= 600 + extra && n < 640 + extra, 1'b1);
    chk(wen, 1'b0);
    @(posedge sys_clk);
    rdy_en <= 1'b0;
    till(mot, 1'b0, n);
    chk(n < 8, 1'b1);
    // Let the stale chain run out before the next trial
    hold(700);
  endtask : t_cycle
  task automatic t_limit;
    @(posedge sys_clk);
    rdy_en <= 1'b1;
    lim    <= 1'b1;
    wreg(4'h0, 32'h42);
    hold(6);
    wreg(4'h4, 32'h01);
    hold(3);
    chk({mot, fin}, 2'b10);
    @(posedge sys_clk);
    fwd <= 1'b1;
    hold(3);
    chk(mot, 1'b0);
    wreg(4'h0, 32'h00);
    hold(4);
    chk(fin, 1'b1);
    @(posedge sys_clk);
    fwd    <= 1'b0;
    lim    <= 1'b0;
    rdy_en <= 1'b0;
  endtask : t_limit
  task automatic t_fault;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      flts <= 5'h01 << i;
      hold(6);
      chk(flt, 1'b1);
      wreg(4'h0, 32'h20);
      hold(2);
      chk(flt, 1'b0);
      wreg(4'h0, 32'h00);
      hold(4);
      chk(flt, 1'b1);
      @(posedge sys_clk);
      flts <= 5'h00;
      hold(4);
      wreg(4'h0, 32'h20);
      wreg(4'h0, 32'h00);
      hold(4);
      chk(flt, 1'b0);
    end
  endtask : t_fault
  task automatic t_perr;
    @(posedge sys_clk);
    pmt <= 1'b1;
    hold(6);
    chk(perr, 1'b1);
    @(posedge sys_clk);
    pmt <= 1'b0;
    hold(4);
    wreg(4'h4, 32'h02);
    hold(2);
    chk(perr, 1'b0);
  endtask : t_perr
  task automatic t_mon;
    @(posedge sys_clk);
    mon <= 1'b1;
    @(posedge sys_clk);
    mon <= 1'b0;
    hold(3);
    chk(moni, 1'b1);
    hold(40);
    chk(moni, 1'b1);
    hold(20);
    chk(moni, 1'b0);
  endtask : t_mon
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_intest();
    t_cycle(32'h02, 0);
    wreg(4'h8, 32'h05);
    t_cycle(32'h06, 50);
    t_limit();
    t_fault();
    t_perr();
    t_mon();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule : tape_exerciser_motion_control_tb
